// *** dv/ssb_check_monitor.sv ***
`timescale 1ns/1ps
module ssb_check
    import ssb_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // Link pins
    input wire logic        serial_clk,
    input wire logic        storage_latch,
    input wire logic        register_clear_n,
    input wire logic        output_gate_n,
    input wire logic        standby_n,
    // Outputs
    input wire logic        cascade_clk,
    input wire logic        cascade_latch,
    input wire logic        dir_a,
    input wire logic        drive_on_a,
    input wire logic        dir_b,
    input wire logic        drive_on_b,
    input wire logic        current_scale_bit3,
    input wire logic        current_scale_bit2,
    input wire logic        current_scale_bit1,
    input wire logic        current_scale_bit0,
    input wire logic [6:0]  current_ratio,
    input wire logic        osc_run,
    input wire ssb_bridge_t bridge_a,
    input wire ssb_bridge_t bridge_b,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic [7:0] ctl = {dir_a, drive_on_a, dir_b, drive_on_b,
        current_scale_bit3, current_scale_bit2, current_scale_bit1,
        current_scale_bit0};
    sequence gate_s; output_gate_n [*8] ##1 output_gate_n [*4]; endsequence
    sequence clr_s; !register_clear_n [*8] ##1 !register_clear_n [*4];
    endsequence
    sequence sby_s; !standby_n [*8] ##1 !standby_n [*4]; endsequence
    gate_off_a: assert property (gate_s |-> ctl == 8'h00)
        else $error("controls live with gate closed");
    clear_off_a: assert property (clr_s |-> ctl == 8'h00)
        else $error("controls live during clear");
    sby_off_a: assert property (sby_s |-> !osc_run &&
        !bridge_a.pos_oe && !bridge_b.neg_oe) else $error("drive in standby");
    chan_off_a: assert property (!drive_on_a |->
        !bridge_a.pos_oe && !bridge_a.neg_oe) else $error("off channel driven");
    chan_pol_a: assert property ((drive_on_b && osc_run) [*2] |->
        bridge_b == {dir_b, 1'h1, !dir_b, 1'h1}) else $error("bad polarity");
    ratio_map_a: assert property ($stable(ctl[3:0]) [*3] |->
        current_ratio == SSB_RATIO_TAB[ctl[3:0]]) else $error("bad ratio");
    casc_clk_a: assert property ($rose(serial_clk) |-> ##[2:8] cascade_clk)
        else $error("clock not repeated");
    casc_lat_a: assert property ($rose(storage_latch) |->
        ##[2:8] cascade_latch) else $error("latch not repeated");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
endmodule
bind ssb_top ssb_check u_ssb_check (.*);

// *** dv/ssb_host_model.sv ***
`timescale 1ns/1ps
module ssb_host_model (
    // Serial link
    output logic serial_data,
    output logic serial_clk,
    output logic storage_latch
);
    initial begin
        serial_data = 1'h0;
        serial_clk = 1'h0;
        storage_latch = 1'h0;
    end
    task automatic send_word(input logic [7:0] w, input logic latch);
        #3;
        for (int i = 7; i >= 0; i--) begin
            serial_data = w[i];
            #20 serial_clk = 1'h1;
            #40 serial_clk = 1'h0;
            #20;
        end
        // clock rests low, data pulled low
        serial_data = 1'h0;
        if (latch) begin
            #40 storage_latch = 1'h1;
            #40 storage_latch = 1'h0;
        end
        #40;
    endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import ssb_pkg::*;
;
    logic sys_clk, resetn, serial_data, serial_clk, storage_latch;
    logic register_clear_n, output_gate_n, standby_n, osc_run;
    logic cascade_data, cascade_clk, cascade_latch;
    logic dir_a, drive_on_a, dir_b, drive_on_b, current_scale_bit3;
    logic current_scale_bit2, current_scale_bit1, current_scale_bit0;
    logic [6:0] current_ratio;
    ssb_bridge_t bridge_a, bridge_b;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    int miscompares, checked;
    localparam logic [3:0] HALF [8] = '{4'hF, 4'h3, 4'h7, 4'h4,
        4'h5, 4'h1, 4'hD, 4'hC};
    localparam int RAT [16] = '{0, 5, 10, 15, 25, 29, 38, 43, 52, 60,
        67, 74, 80, 86, 94, 100};
    wire logic [7:0] ctl = {dir_a, drive_on_a, dir_b, drive_on_b,
        current_scale_bit3, current_scale_bit2, current_scale_bit1,
        current_scale_bit0};
    ssb_top u_ssb_top (.*);
    ssb_host_model u_host (.*);
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (wb_ack_o !== 1'h1) begin
            miscompares++;
            report_and_stop;
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    task automatic pins(input logic clr, input logic gate, input logic sby);
        @(posedge sys_clk);
        {register_clear_n, output_gate_n, standby_n} <= {clr, gate, sby};
        repeat (12) @(posedge sys_clk);
    endtask
    task automatic chan(input ssb_bridge_t b, input logic dir, input logic on);
        if (on) check(32'(b), 32'({dir, 1'h1, ~dir, 1'h1}));
        else check(32'({b.pos_oe, b.neg_oe}), 32'h0000_0000);
    endtask
    task automatic t_idle;
        check(32'({ctl, osc_run}), 32'h0000_0000);
        wb(1'h0, SSB_ADDR_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0008);
    endtask
    task automatic t_steps;
        logic [7:0] w;
        pins(1'h1, 1'h0, 1'h1);
        for (int i = 0; i < 16; i++) begin
            w = {HALF[i % 8], 4'(i)};
            u_host.send_word(w, 1'h1);
            repeat (12) @(posedge sys_clk);
            check(32'(ctl), 32'(w));
            check(32'(cascade_data), 32'(w[7]));
            check(32'(current_ratio), 32'(RAT[i]));
            chan(bridge_a, w[7], w[6]);
            chan(bridge_b, w[5], w[4]);
            wb(1'h0, SSB_ADDR_SHIFT, 32'h0000_0000);
            check(rd, 32'(w));
        end
    endtask
    task automatic t_hold;
        u_host.send_word(8'h00, 1'h0);
        repeat (12) @(posedge sys_clk);
        check(32'(ctl), 32'h0000_00CF);
        check(32'(cascade_data), 32'h0000_0000);
        pins(1'h1, 1'h1, 1'h1);
        check(32'(ctl), 32'h0000_0000);
        pins(1'h1, 1'h0, 1'h1);
        check(32'(ctl), 32'h0000_00CF);
        wb(1'h1, SSB_ADDR_CTRL, 32'h0000_0001);
        repeat (4) @(posedge sys_clk);
        check(32'(ctl), 32'h0000_0000);
        wb(1'h1, SSB_ADDR_CTRL, 32'h0000_0000);
        wb(1'h1, 4'h2, 32'hFFFF_FFFF);
        wb(1'h0, 4'h2, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(32'(ctl), 32'h0000_00CF);
    endtask
    task automatic t_sby_clr;
        pins(1'h1, 1'h0, 1'h0);
        check(32'({osc_run, bridge_a}), 32'h0000_0000);
        pins(1'h0, 1'h0, 1'h1);
        u_host.send_word(8'hFF, 1'h1);
        repeat (12) @(posedge sys_clk);
        check(32'(ctl), 32'h0000_0000);
        wb(1'h0, SSB_ADDR_STORE, 32'h0000_0000);
        check(rd, 32'h0000_0000);
    endtask
    initial begin
        {resetn, register_clear_n, standby_n, output_gate_n} = 4'h1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h0F, 32'h0000_0000};
        repeat (4) @(posedge sys_clk);
        resetn <= 1'h1;
        repeat (12) @(posedge sys_clk);
        t_idle;
        t_steps;
        t_hold;
        t_sby_clr;
        report_and_stop;
    end
    initial begin
        #300000;
        miscompares++;
        report_and_stop;
    end
endmodule

// *** rtl/ssb_chan_drv.sv ***
`timescale 1ns/1ps
module ssb_chan_drv
    import ssb_pkg::*;
(
    // Command
    input  wire ssb_chan_cmd_t cmd,
    input  wire logic          run,
    // Bridge
    output ssb_bridge_t        bridge
);
    always_comb begin
        bridge = '0;
        if (cmd.on && run) begin
            bridge.pos_oe    = 1'b1;
            bridge.neg_oe    = 1'b1;
            bridge.pos_drive = cmd.dir;
            bridge.neg_drive = !cmd.dir;
        end
    end
endmodule

// *** rtl/ssb_pin_sync.sv ***
`timescale 1ns/1ps
module ssb_pin_sync
    import ssb_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic init_val,
    // Pin
    input  wire logic pin,
    // Filtered level
    output logic      level
);
    ssb_sync_state_t s_q;
    ssb_sync_state_t s_d;
    logic            lvl_q;
    logic            lvl_d;

    always_comb begin
        s_d.q = {s_q.q[1:0], pin};
        lvl_d = lvl_q;
        // Change counts once stages two and three agree
        if (s_q.q[1] == s_q.q[2]) begin
            lvl_d = s_q.q[2];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q   <= '0;
            lvl_q <= 1'b0;
        end else begin
            s_q   <= s_d;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q ^ init_val;
endmodule

// *** rtl/ssb_pkg.sv ***
package ssb_pkg;

    localparam int SSB_STAGES = 8;
    localparam int SSB_SCALE_W = 4;
    localparam int SSB_RATIO_W = 7;

    // Storage register bit order, bit 7 shifted in first
    localparam int SSB_BIT_DIR_A = 7;
    localparam int SSB_BIT_ON_A = 6;
    localparam int SSB_BIT_DIR_B = 5;
    localparam int SSB_BIT_ON_B = 4;
    localparam int SSB_BIT_SCALE3 = 3;
    localparam int SSB_BIT_SCALE0 = 0;

    localparam logic [7:0] SSB_REG_INIT = 8'h00;

    // Wishbone register offsets
    localparam logic [3:0] SSB_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SSB_ADDR_SHIFT = 4'h4;
    localparam logic [3:0] SSB_ADDR_STORE = 4'h8;
    localparam logic [3:0] SSB_ADDR_STATUS = 4'hC;
    localparam logic [31:0] SSB_RD_ZERO = 32'h0000_0000;

    // Control register fields
    localparam int SSB_CTL_SW_GATE = 0;

    // Current ratio in percent per scale code
    localparam logic [6:0] SSB_RATIO_TAB [16] = '{
        7'd0, 7'd5, 7'd10, 7'd15, 7'd25, 7'd29, 7'd38, 7'd43,
        7'd52, 7'd60, 7'd67, 7'd74, 7'd80, 7'd86, 7'd94, 7'd100
    };

    typedef struct packed {
        logic dir;
        logic on;
    } ssb_chan_cmd_t;

    typedef struct packed {
        logic pos_drive;
        logic pos_oe;
        logic neg_drive;
        logic neg_oe;
    } ssb_bridge_t;

    typedef struct packed {
        logic [2:0] q;
    } ssb_sync_state_t;

endpackage

// *** rtl/ssb_top.sv ***
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module ssb_top
    import ssb_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Serial link pins, already resolved to levels
    input  wire logic        serial_data,
    input  wire logic        serial_clk,
    input  wire logic        storage_latch,
    input  wire logic        register_clear_n,
    input  wire logic        output_gate_n,
    input  wire logic        standby_n,
    // Cascade outputs
    output logic             cascade_data,
    output logic             cascade_clk,
    output logic             cascade_latch,
    // Control signals after the gate, and oscillator run taken from standby
    output logic             dir_a,
    output logic             drive_on_a,
    output logic             dir_b,
    output logic             drive_on_b,
    output logic             current_scale_bit3,
    output logic             current_scale_bit2,
    output logic             current_scale_bit1,
    output logic             current_scale_bit0,
    output logic [6:0]       current_ratio,
    output logic             osc_run,
    // Bridge pins
    output ssb_bridge_t      bridge_a,
    output ssb_bridge_t      bridge_b,
    // Wishbone slave
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    typedef struct packed {
        logic        sclk_prev;
        logic        latch_prev;
        logic [7:0]  shift;
        logic [7:0]  store;
        logic        cas_data;
        logic        cas_clk;
        logic        cas_latch;
        logic [7:0]  ctl;
        logic        sw_gate;
        ssb_bridge_t br_a;
        ssb_bridge_t br_b;
        logic [6:0]  ratio;
        logic        run;
        logic [31:0] rdata;
        logic        ack;
    } ssb_state_t;

    ssb_state_t    s_q;
    ssb_state_t    s_d;
    logic          rst_n;
    logic          sclk_l;
    logic          latch_l;
    logic          data_l;
    logic          clr_n_l;
    logic          gate_n_l;
    logic          stby_n_l;
    ssb_bridge_t   br_a_w;
    ssb_bridge_t   br_b_w;
    ssb_chan_cmd_t cmd_a;
    ssb_chan_cmd_t cmd_b;
    logic [7:0]    ctl_w;
    logic          gate_open;
    logic          wb_hit;

    // Reset release through two flip-flops
    logic [1:0] rs_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rs_q <= 2'b00;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_n = rs_q[1];

    // Idle defaults: gate reads high, others low
    ssb_pin_sync u_sync_clk (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .init_val (1'b0),
        .pin      (serial_clk),
        .level    (sclk_l)
    );
    ssb_pin_sync u_sync_latch (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .init_val (1'b0),
        .pin      (storage_latch),
        .level    (latch_l)
    );
    ssb_pin_sync u_sync_data (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .init_val (1'b0),
        .pin      (serial_data),
        .level    (data_l)
    );
    ssb_pin_sync u_sync_clr (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .init_val (1'b0),
        .pin      (register_clear_n),
        .level    (clr_n_l)
    );
    ssb_pin_sync u_sync_gate (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .init_val (1'b1),
        .pin      (!output_gate_n),
        .level    (gate_n_l)
    );
    ssb_pin_sync u_sync_stby (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .init_val (1'b0),
        .pin      (standby_n),
        .level    (stby_n_l)
    );

    assign gate_open = !gate_n_l && !s_q.sw_gate;
    assign ctl_w     = gate_open ? s_q.store : SSB_REG_INIT;

    assign cmd_a.dir = ctl_w[SSB_BIT_DIR_A];
    assign cmd_a.on  = ctl_w[SSB_BIT_ON_A];
    assign cmd_b.dir = ctl_w[SSB_BIT_DIR_B];
    assign cmd_b.on  = ctl_w[SSB_BIT_ON_B];

    ssb_chan_drv u_chan_a (
        .cmd    (cmd_a),
        .run    (stby_n_l),
        .bridge (br_a_w)
    );
    ssb_chan_drv u_chan_b (
        .cmd    (cmd_b),
        .run    (stby_n_l),
        .bridge (br_b_w)
    );

    assign wb_hit = wb_cyc_i && wb_stb_i && !s_q.ack;

    always_comb begin
        s_d           = s_q;
        s_d.sclk_prev = sclk_l;
        s_d.latch_prev = latch_l;
        if (sclk_l && !s_q.sclk_prev) begin
            s_d.shift = {s_q.shift[SSB_STAGES-2:0], data_l};
        end
        // Cascade data updates on clock fall
        if (!sclk_l && s_q.sclk_prev) begin
            s_d.cas_data = s_q.shift[SSB_STAGES-1];
        end
        if (latch_l && !s_q.latch_prev) begin
            s_d.store = s_q.shift;
        end
        if (!clr_n_l) begin
            s_d.shift = SSB_REG_INIT;
            s_d.store = SSB_REG_INIT;
        end
        s_d.cas_clk   = sclk_l;
        s_d.cas_latch = latch_l;
        s_d.ctl       = ctl_w;
        s_d.br_a      = br_a_w;
        s_d.br_b      = br_b_w;
        s_d.run       = stby_n_l;
        s_d.ratio = SSB_RATIO_TAB[ctl_w[SSB_BIT_SCALE3:SSB_BIT_SCALE0]];
        s_d.ack   = wb_hit;
        s_d.rdata = SSB_RD_ZERO;
        if (wb_hit) begin
            if (wb_adr_i == SSB_ADDR_CTRL) begin
                s_d.rdata = {31'h0000_0000, s_q.sw_gate};
                if (wb_we_i && wb_sel_i[0]) begin
                    s_d.sw_gate = wb_dat_i[SSB_CTL_SW_GATE];
                end
            end else if (wb_adr_i == SSB_ADDR_SHIFT) begin
                s_d.rdata = {24'h00_0000, s_q.shift};
            end else if (wb_adr_i == SSB_ADDR_STORE) begin
                s_d.rdata = {24'h00_0000, s_q.store};
            end else if (wb_adr_i == SSB_ADDR_STATUS) begin
                s_d.rdata = {27'h000_0000, stby_n_l, gate_n_l,
                             clr_n_l, latch_l, sclk_l};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cascade_data       = s_q.cas_data;
    assign cascade_clk        = s_q.cas_clk;
    assign cascade_latch      = s_q.cas_latch;
    assign dir_a              = s_q.ctl[SSB_BIT_DIR_A];
    assign drive_on_a         = s_q.ctl[SSB_BIT_ON_A];
    assign dir_b              = s_q.ctl[SSB_BIT_DIR_B];
    assign drive_on_b         = s_q.ctl[SSB_BIT_ON_B];
    assign current_scale_bit3 = s_q.ctl[SSB_BIT_SCALE3];
    assign current_scale_bit2 = s_q.ctl[SSB_BIT_SCALE3-1];
    assign current_scale_bit1 = s_q.ctl[SSB_BIT_SCALE0+1];
    assign current_scale_bit0 = s_q.ctl[SSB_BIT_SCALE0];
    assign current_ratio      = s_q.ratio;
    assign osc_run            = s_q.run;
    assign bridge_a           = s_q.br_a;
    assign bridge_b           = s_q.br_b;
    assign wb_dat_o           = s_q.rdata;
    assign wb_ack_o           = s_q.ack;
endmodule
